//--- logic/vlrx_defs.vh
// Shared constants of the video link receiver: widths, bit maps, codes and timing.
`ifndef VLRX_DEFS_VH
`define VLRX_DEFS_VH
// =====================================================================
// Serial framing
`define VLRX_BITS 7
`define VLRX_LANES 4
`define VLRX_WORD_W 28
`define VLRX_SH_W 9
`define VLRX_EDGE 2'h1
`define VLRX_OFF_LO 4'h1
`define VLRX_OFF_HI 4'h2
// =====================================================================
// Bit assignment of a recovered word, five bits per index, port bit 7 first
`define VLRX_MAP_A 40'h2ECC418820
`define VLRX_MAP_B 40'h5A9CD62507
`define VLRX_MAP_C 40'h8C2D5A4E4F
`define VLRX_LV_BIT 24
`define VLRX_FV_BIT 25
`define VLRX_DV_BIT 26
`define VLRX_SPARE_LO 15
`define VLRX_SPARE_HI 23
// =====================================================================
// Link sizes and aligner
`define VLRX_SIZE_BASE 2'h0
`define VLRX_SIZE_MEDIUM 2'h1
`define VLRX_SIZE_FULL 2'h2
`define VLRX_HIST_W 112
`define VLRX_X_LAG 2'h2
`define VLRX_OUT_W 83
// =====================================================================
// Power supervisor states and timing
`define VLRX_PS_OFF 4'h1
`define VLRX_PS_PROBE 4'h2
`define VLRX_PS_POWER 4'h4
`define VLRX_PS_PASSIVE 4'h8
`define VLRX_CLK_MHZ 100
`define VLRX_PROBE_TIME_US 1000
`define VLRX_TMR_W 20
`endif

//--- logic/vlrx_deser.v
// One channel of the 7:1 deserializer: pin synchroniser, shifters and word framing.
`timescale 1ns/1ns
`include "vlrx_defs.vh"
module vlrx_deser (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_sync_rst,
  input wire i_half_rate,
  input wire [3:0] i_lane,
  input wire [3:0] i_lane_late,
  input wire i_fwd_clk,
  input wire i_fwd_clk_late,
  output reg [27:0] o_word,
  output reg o_word_valid
);
  // =====================================================================
  // Pin synchroniser
  reg [9:0] meta; // First stage, read only by the second stage.
  reg [9:0] pin; // Settled pin samples: rise lanes and clock, then late half.
  reg [`VLRX_SH_W*5-1:0] sh; // Four data shifters and the clock shifter.
  reg [`VLRX_SH_W*5-1:0] next_sh;
  reg [27:0] next_word;
  reg [3:0] off; // Position of the word's last bit inside the shifters.
  reg edge_seen;
  reg [`VLRX_SH_W-1:0] c;
  integer l;
  integer j;

  // Two flops on every pin since lanes arrive from outside this clock.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= 10'h000;
      pin <= 10'h000;
    end else if (i_ce) begin
      meta <= {i_fwd_clk_late, i_lane_late, i_fwd_clk, i_lane};
      pin <= meta;
    end
  end

  // =====================================================================
  // Shifting every cycle, framing on the forwarded clock's rising edge
  // One bit per cycle at the seven-times clock, two at the half-rate clock.
  always @* begin
    next_sh = sh;
    for (l = 0; l < 5; l = l + 1) begin
      if (i_half_rate) begin
        next_sh[l*`VLRX_SH_W +: `VLRX_SH_W] = {sh[l*`VLRX_SH_W +: 7], pin[l], pin[5+l]};
      end else begin
        next_sh[l*`VLRX_SH_W +: `VLRX_SH_W] = {sh[l*`VLRX_SH_W +: 8], pin[l]};
      end
    end
    c = next_sh[4*`VLRX_SH_W +: `VLRX_SH_W];
    // The low-to-high step of the clock lane starts a new word.
    edge_seen = 1'b0;
    off = `VLRX_OFF_LO;
    if (c[1:0] == `VLRX_EDGE) begin
      edge_seen = 1'b1;
    end else if (i_half_rate && c[2:1] == `VLRX_EDGE) begin
      edge_seen = 1'b1;
      off = `VLRX_OFF_HI;
    end
    // Oldest bit of each lane lands in the lane's lowest word bit.
    next_word = 28'h0000000;
    for (l = 0; l < `VLRX_LANES; l = l + 1) begin
      for (j = 0; j < `VLRX_BITS; j = j + 1) begin
        next_word[l*`VLRX_BITS+j] = next_sh[l*`VLRX_SH_W + off + `VLRX_BITS - 1 - j];
      end
    end
  end

  // Shifters run every cycle; the word register loads once per pixel period.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh <= 45'h00000000000;
      o_word <= 28'h0000000;
      o_word_valid <= 1'b0;
    end else if (i_ce) begin
      if (i_sync_rst) begin
        sh <= 45'h00000000000;
        o_word_valid <= 1'b0;
      end else begin
        sh <= next_sh;
        o_word_valid <= edge_seen;
        if (edge_seen) begin
          o_word <= next_word;
        end
      end
    end
  end
endmodule

//--- logic/vlrx_buf2.v
// Two-entry output buffer with valid and ready on both sides.
`timescale 1ns/1ns
module vlrx_buf2 #(
  parameter W = 83
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_sync_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output reg [W-1:0] o_out_data
);
  // =====================================================================
  // Storage: head register drives the output, second entry catches a stall
  reg [W-1:0] spare; // Second entry.
  reg [1:0] cnt; // Words held, zero to two.
  wire push;
  wire pop;

  // A full buffer still takes a word in the cycle it hands one on, so a ready consumer never causes a drop.
  assign o_in_ready = (cnt != 2'h2) | i_out_ready;
  assign o_out_valid = (cnt != 2'h0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Head always holds the oldest word so the output is a flop.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 2'h0;
      spare <= {W{1'b0}};
      o_out_data <= {W{1'b0}};
    end else if (i_ce) begin
      if (i_sync_rst) begin
        cnt <= 2'h0;
      end else begin
        if (pop) begin
          // Move up the second entry, or take the new word straight in.
          if (cnt == 2'h2) begin
            o_out_data <= spare;
            if (push) begin
              spare <= i_in_data;
            end
          end else if (push) begin
            o_out_data <= i_in_data;
          end
        end else if (push) begin
          if (cnt == 2'h0) begin
            o_out_data <= i_in_data;
          end else begin
            spare <= i_in_data;
          end
        end
        cnt <= cnt + {1'b0, push} - {1'b0, pop};
      end
    end
  end
endmodule

//--- logic/vlrx_rx_top.v
// Video link receiver: three deserialized channels, link aligner and cable power supervisor.
`timescale 1ns/1ns
`include "vlrx_defs.vh"
module vlrx_rx_top #(
  parameter P_PROBE_CYCLES = `VLRX_PROBE_TIME_US * `VLRX_CLK_MHZ
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_rst,
  input wire [1:0] i_link_size,
  input wire i_half_rate,
  input wire i_wide_mode,
  input wire [3:0] i_x_lane,
  input wire [3:0] i_x_lane_late,
  input wire i_x_channel_clock,
  input wire i_x_channel_clock_late,
  input wire [3:0] i_y_lane,
  input wire [3:0] i_y_lane_late,
  input wire i_y_channel_clock,
  input wire i_y_channel_clock_late,
  input wire [3:0] i_z_lane,
  input wire [3:0] i_z_lane_late,
  input wire i_z_channel_clock,
  input wire i_z_channel_clock_late,
  input wire i_pixel_ready,
  output wire o_pixel_valid,
  output wire o_strobe,
  output wire [7:0] o_port_a,
  output wire [7:0] o_port_b,
  output wire [7:0] o_port_c,
  output wire [7:0] o_port_d,
  output wire [7:0] o_port_e,
  output wire [7:0] o_port_f,
  output wire [7:0] o_port_g,
  output wire [7:0] o_port_h,
  output wire [7:0] o_port_i,
  output wire [7:0] o_port_j,
  output wire o_frame_valid_flag,
  output wire o_line_valid_flag,
  output wire o_data_valid_flag,
  output reg o_aligned,
  output reg o_overrun,
  input wire i_power_supervisor_reset,
  input wire i_link_pll_lock_in,
  input wire i_supply_sense_one,
  input wire i_supply_sense_two,
  output reg o_current_source_enable,
  output reg o_supply_feed_enable,
  output reg o_ground_return_enable
);
  // =====================================================================
  // Functions
  // Gathers one 8-bit port from a word through a packed index table.
  function [7:0] map8;
    input [27:0] w;
    input [39:0] m;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        map8[k] = w[m[k*5 +: 5]];
      end
    end
  endfunction

  // Finds the newest line start in a four-word history, newest at index 0.
  function [2:0] find_rise;
    input [`VLRX_HIST_W-1:0] h;
    integer k;
    begin
      find_rise = 3'h0;
      for (k = 2; k >= 0; k = k - 1) begin
        if (h[k*`VLRX_WORD_W+`VLRX_LV_BIT] && !h[(k+1)*`VLRX_WORD_W+`VLRX_LV_BIT]) begin
          find_rise = {1'b1, k[1:0]};
        end
      end
    end
  endfunction

  // =====================================================================
  // Reset and sense synchronisers
  // The documented reset is active high and comes from a pin, so it is synchronised.
  reg [5:0] meta; // First stage, read only by the second stage.
  reg [5:0] pin;
  wire link_rst;
  wire ps_rst;
  wire lock_s;
  wire sense1_s;
  wire sense2_s;
  assign link_rst = pin[0];
  assign ps_rst = pin[1];
  assign lock_s = pin[2];
  assign sense1_s = pin[3];
  assign sense2_s = pin[4];

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= 6'h03;
      pin <= 6'h03;
    end else if (i_ce) begin
      meta <= {1'b0, i_supply_sense_two, i_supply_sense_one, i_link_pll_lock_in, i_power_supervisor_reset, i_rst};
      pin <= meta;
    end
  end

  // =====================================================================
  // Channel deserializers
  wire [27:0] wx;
  wire [27:0] wy;
  wire [27:0] wz;
  wire vx;
  wire vy;
  wire vz;

  vlrx_deser u_x (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sync_rst(link_rst), .i_half_rate(i_half_rate),
    .i_lane(i_x_lane), .i_lane_late(i_x_lane_late), .i_fwd_clk(i_x_channel_clock),
    .i_fwd_clk_late(i_x_channel_clock_late), .o_word(wx), .o_word_valid(vx));
  vlrx_deser u_y (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sync_rst(link_rst), .i_half_rate(i_half_rate),
    .i_lane(i_y_lane), .i_lane_late(i_y_lane_late), .i_fwd_clk(i_y_channel_clock),
    .i_fwd_clk_late(i_y_channel_clock_late), .o_word(wy), .o_word_valid(vy));
  vlrx_deser u_z (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sync_rst(link_rst), .i_half_rate(i_half_rate),
    .i_lane(i_z_lane), .i_lane_late(i_z_lane_late), .i_fwd_clk(i_z_channel_clock),
    .i_fwd_clk_late(i_z_channel_clock_late), .o_word(wz), .o_word_valid(vz));

  // =====================================================================
  // Link aligner
  reg [`VLRX_HIST_W-1:0] hx; // Last four words per channel, newest lowest.
  reg [`VLRX_HIST_W-1:0] hy;
  reg [`VLRX_HIST_W-1:0] hz;
  reg [1:0] dy; // Chosen delay of the y channel, in words.
  reg [1:0] dz;
  reg [`VLRX_OUT_W-1:0] asm; // Assembled output word waiting for the buffer.
  reg asm_valid;
  wire [2:0] ry;
  wire [2:0] rz;
  wire use_y;
  wire use_z;
  wire x_start;
  wire [27:0] ax;
  wire [27:0] ay;
  wire [27:0] az;
  wire buf_ready;
  wire [`VLRX_OUT_W-1:0] next_asm;

  assign use_y = (i_link_size != `VLRX_SIZE_BASE);
  assign use_z = (i_link_size == `VLRX_SIZE_FULL);
  assign ry = find_rise(hy);
  assign rz = find_rise(hz);
  // X runs a fixed two words late so a lagging channel's line start is already held.
  assign x_start = hx[`VLRX_X_LAG*`VLRX_WORD_W+`VLRX_LV_BIT] & ~hx[(`VLRX_X_LAG+2'h1)*`VLRX_WORD_W+`VLRX_LV_BIT];
  assign ax = hx[`VLRX_X_LAG*`VLRX_WORD_W +: `VLRX_WORD_W];
  assign ay = use_y ? hy[dy*`VLRX_WORD_W +: `VLRX_WORD_W] : 28'h0000000;
  assign az = use_z ? hz[dz*`VLRX_WORD_W +: `VLRX_WORD_W] : 28'h0000000;
  // Flags, then ports j down to a; ports i and j exist only in the 80-bit form.
  assign next_asm = {ax[`VLRX_FV_BIT], ax[`VLRX_LV_BIT], ax[`VLRX_DV_BIT],
    i_wide_mode ? {az[`VLRX_SPARE_HI +: 4], ay[`VLRX_SPARE_HI +: 4]} : 8'h00,
    i_wide_mode ? az[`VLRX_SPARE_LO +: 8] : 8'h00,
    map8(az, `VLRX_MAP_B), map8(az, `VLRX_MAP_A),
    map8(ay, `VLRX_MAP_C), map8(ay, `VLRX_MAP_B), map8(ay, `VLRX_MAP_A),
    map8(ax, `VLRX_MAP_C), map8(ax, `VLRX_MAP_B), map8(ax, `VLRX_MAP_A)};

  // Histories load on each channel's own word strobe.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hx <= 112'h0;
      hy <= 112'h0;
      hz <= 112'h0;
    end else if (i_ce) begin
      if (link_rst) begin
        hx <= 112'h0;
        hy <= 112'h0;
        hz <= 112'h0;
      end else begin
        if (vx) begin
          hx <= {hx[`VLRX_HIST_W-`VLRX_WORD_W-1:0], wx};
        end
        if (vy) begin
          hy <= {hy[`VLRX_HIST_W-`VLRX_WORD_W-1:0], wy};
        end
        if (vz) begin
          hz <= {hz[`VLRX_HIST_W-`VLRX_WORD_W-1:0], wz};
        end
      end
    end
  end

  // At each x line start the delays are set from where the other channels saw theirs.
  // A word that meets a full buffer is dropped and flagged, since the link cannot stall.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dy <= 2'h0;
      dz <= 2'h0;
      o_aligned <= 1'b0;
      asm <= {`VLRX_OUT_W{1'b0}};
      asm_valid <= 1'b0;
      o_overrun <= 1'b0;
    end else if (i_ce) begin
      if (link_rst) begin
        o_aligned <= 1'b0;
        asm_valid <= 1'b0;
        o_overrun <= 1'b0;
      end else begin
        o_overrun <= 1'b0;
        if (asm_valid && buf_ready) begin
          asm_valid <= 1'b0;
        end
        if (vx && x_start) begin
          if (ry[2]) begin
            dy <= ry[1:0];
          end
          if (rz[2]) begin
            dz <= rz[1:0];
          end
          if ((!use_y || ry[2]) && (!use_z || rz[2])) begin
            o_aligned <= 1'b1;
          end
        end
        // Nothing leaves before alignment, so ports and flags keep their reset or last values.
        if (vx && o_aligned) begin
          if (asm_valid && !buf_ready) begin
            o_overrun <= 1'b1;
          end else begin
            asm <= next_asm;
            asm_valid <= 1'b1;
          end
        end
      end
    end
  end

  // =====================================================================
  // Output buffer and ports
  wire [`VLRX_OUT_W-1:0] q;

  vlrx_buf2 #(.W(`VLRX_OUT_W)) u_buf (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sync_rst(link_rst),
    .i_in_valid(asm_valid), .o_in_ready(buf_ready), .i_in_data(asm),
    .o_out_valid(o_pixel_valid), .i_out_ready(i_pixel_ready), .o_out_data(q));

  assign o_strobe = o_pixel_valid & i_pixel_ready;
  assign o_port_a = q[7:0];
  assign o_port_b = q[15:8];
  assign o_port_c = q[23:16];
  assign o_port_d = q[31:24];
  assign o_port_e = q[39:32];
  assign o_port_f = q[47:40];
  assign o_port_g = q[55:48];
  assign o_port_h = q[63:56];
  assign o_port_i = q[71:64];
  assign o_port_j = q[79:72];
  assign o_data_valid_flag = q[80];
  assign o_line_valid_flag = q[81];
  assign o_frame_valid_flag = q[82];

  // =====================================================================
  // Cable power supervisor
  reg [3:0] ps; // One-hot state.
  reg [3:0] next_ps;
  reg [`VLRX_TMR_W-1:0] tmr; // Probe and back-off timer.
  wire tmr_done;
  assign tmr_done = (tmr == P_PROBE_CYCLES[`VLRX_TMR_W-1:0]);

  // A running link clock means the camera powers itself; otherwise probe the cable.
  always @* begin
    next_ps = ps;
    case (ps)
      `VLRX_PS_OFF: begin
        if (lock_s) begin
          next_ps = `VLRX_PS_PASSIVE;
        end else if (tmr_done) begin
          next_ps = `VLRX_PS_PROBE;
        end
      end
      `VLRX_PS_PROBE: begin
        if (tmr_done) begin
          // Only a camera that draws the probe current as expected gets the feed.
          next_ps = (sense1_s && !sense2_s) ? `VLRX_PS_POWER : `VLRX_PS_OFF;
        end
      end
      `VLRX_PS_POWER: begin
        if (sense2_s) begin
          next_ps = `VLRX_PS_OFF;
        end
      end
      `VLRX_PS_PASSIVE: begin
        if (!lock_s) begin
          next_ps = `VLRX_PS_OFF;
        end
      end
      default: begin
        next_ps = `VLRX_PS_OFF;
      end
    endcase
  end

  // Its own reset only touches this supervisor, never the video path.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ps <= `VLRX_PS_OFF;
      tmr <= {`VLRX_TMR_W{1'b0}};
      o_current_source_enable <= 1'b0;
      o_supply_feed_enable <= 1'b0;
      o_ground_return_enable <= 1'b0;
    end else if (i_ce) begin
      if (ps_rst) begin
        ps <= `VLRX_PS_OFF;
        tmr <= {`VLRX_TMR_W{1'b0}};
        o_current_source_enable <= 1'b0;
        o_supply_feed_enable <= 1'b0;
        o_ground_return_enable <= 1'b0;
      end else begin
        ps <= next_ps;
        tmr <= (next_ps != ps || tmr_done) ? {`VLRX_TMR_W{1'b0}} : tmr + 1'b1;
        o_current_source_enable <= (next_ps == `VLRX_PS_PROBE);
        o_supply_feed_enable <= (next_ps == `VLRX_PS_POWER);
        o_ground_return_enable <= (next_ps == `VLRX_PS_POWER);
      end
    end
  end
endmodule

//--- tb/vlrx_rx_props.sv
// Concurrent checks on the ports of the video link receiver top.
`timescale 1ns/1ns
module vlrx_rx_props #(
  parameter P_PROBE_CYCLES = 100000
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_rst,
  input wire i_pixel_ready,
  input wire o_pixel_valid,
  input wire o_strobe,
  input wire [7:0] o_port_a,
  input wire o_line_valid_flag,
  input wire o_aligned,
  input wire o_overrun,
  input wire i_power_supervisor_reset,
  input wire i_link_pll_lock_in,
  input wire i_supply_sense_two,
  input wire o_current_source_enable,
  input wire o_supply_feed_enable,
  input wire o_ground_return_enable
);
  // ==========
  // Helper logic
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Recent link reset samples, so that hold checks skip a reset in flight.
  reg [2:0] rst_hist;
  // Cycles the current source has been on, to time the probe window.
  reg [31:0] probe_cnt;
  // Shift the link reset history and count the probe window.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_hist <= 3'h7;
      probe_cnt <= 32'h0;
    end else begin
      rst_hist <= {rst_hist[1:0], i_rst};
      probe_cnt <= o_current_source_enable ? probe_cnt + 32'h1 : 32'h0;
    end
  end
  // ==========
  // Assertions
  chk_valid_aligned: assert property (o_pixel_valid |-> o_aligned)
    else $error("pixel valid before alignment");
  chk_strobe_taken: assert property (o_strobe |-> o_pixel_valid && i_pixel_ready)
    else $error("strobe without valid and ready");
  chk_strobe_needed: assert property (o_pixel_valid && i_pixel_ready |-> o_strobe)
    else $error("word offered and ready but no strobe");
  chk_hold_stall: assert property (o_pixel_valid && !i_pixel_ready && !i_rst && rst_hist == 3'h0
    |=> o_pixel_valid && $stable(o_port_a) && $stable(o_line_valid_flag))
    else $error("stalled word changed");
  chk_overrun_full: assert property (o_overrun |-> $past(o_pixel_valid) && !$past(i_pixel_ready))
    else $error("overrun without a stalled full buffer");
  chk_reset_quiet: assert property ($rose(i_rst_b) |-> !o_pixel_valid && !o_aligned && !o_supply_feed_enable)
    else $error("outputs active at reset release");
  chk_link_reset: assert property (i_rst [*3] |=> !o_aligned && !o_pixel_valid)
    else $error("link reset did not clear outputs");
  chk_feed_pair: assert property ($rose(o_supply_feed_enable)
    |-> o_ground_return_enable && $past(o_current_source_enable))
    else $error("feed on without ground or probe");
  chk_feed_sense: assert property ((o_supply_feed_enable && i_supply_sense_two) [*3]
    |-> ##[1:2] !o_supply_feed_enable)
    else $error("feed kept on with second sense high");
  chk_probe_lock: assert property ($rose(o_current_source_enable) |-> !$past(i_link_pll_lock_in, 3))
    else $error("probe started while link clock locked");
  chk_probe_time: assert property ($fell(o_current_source_enable) && !i_power_supervisor_reset
    |-> probe_cnt >= P_PROBE_CYCLES - 1 && probe_cnt <= P_PROBE_CYCLES + 1)
    else $error("probe window length wrong");
  cover property (o_strobe);
  cover property (o_overrun);
  cover property ($rose(o_aligned));
  cover property ($rose(o_supply_feed_enable));
endmodule
bind vlrx_rx_top vlrx_rx_props #(.P_PROBE_CYCLES(P_PROBE_CYCLES)) u_props (.i_clk, .i_rst_b, .i_rst,
  .i_pixel_ready, .o_pixel_valid, .o_strobe, .o_port_a, .o_line_valid_flag, .o_aligned, .o_overrun,
  .i_power_supervisor_reset, .i_link_pll_lock_in, .i_supply_sense_two, .o_current_source_enable,
  .o_supply_feed_enable, .o_ground_return_enable);

//--- tb/vlrx_tx_model.sv
// Camera side serializer model for one channel: four lanes and a forwarded clock lane.
`timescale 1ns/1ns
module vlrx_tx_model (
  input wire i_clk,
  input wire [27:0] i_word,
  output reg [3:0] o_lane,
  output reg o_clk_lane,
  output reg o_take
);
  // Bit phase within the word and the word being sent.
  reg [2:0] ph;
  reg [27:0] cur;
  integer l;
  initial begin
    ph = 3'h0;
    cur = 28'h0;
    o_lane = 4'h0;
    o_clk_lane = 1'b0;
    o_take = 1'b0;
  end
  // The link clock runs free, so every seven bit times a new word starts with a clock rise.
  always @(negedge i_clk) begin
    o_take <= (ph == 3'h0);
    o_clk_lane <= (ph < 3'h4);
    if (ph == 3'h0) begin
      cur <= i_word;
    end
    for (l = 0; l < 4; l = l + 1) begin
      o_lane[l] <= (ph == 3'h0) ? i_word[l * 7] : cur[l * 7 + ph];
    end
    ph <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
  end
endmodule

//--- tb/tb_vlrx_rx_top.sv
// Self-checking bench of the video link receiver fed by three serializer models.
`timescale 1ns/1ns
module tb_vlrx_rx_top;
  localparam int P = 20;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_rst = 1'b0;
  logic [1:0] size = 2'h0;
  logic wide = 1'b0;
  logic ready = 1'b0;
  logic srst = 1'b0;
  logic lock = 1'b0;
  logic s1 = 1'b0;
  logic s2 = 1'b0;
  wire [3:0] xl, yl, zl;
  wire xc, yc, zc, tk;
  wire [7:0] pa, pb, pc, pd, pe, pf, pg, ph, pi, pj;
  wire fv, lv, dv, vld, stb, algn, ovr, en_i, en_v, en_g;
  int num_errors = 0;
  int checked = 0;
  int m = 2;
  int lstart = 1 << 20;
  int n_ovr = 0;
  // Sent words by logical index, one table per channel, and the words taken by the consumer.
  logic [27:0] hx [0:4095];
  logic [27:0] hy [0:4095];
  logic [27:0] hz [0:4095];
  logic [82:0] rq [$];
  always #5 i_clk = ~i_clk;
  // ==========
  // Word sources: a distinct pattern per index, line valid high from lstart on.
  function automatic logic [27:0] gen(input int c, input int n, input int ls);
    logic [27:0] w;
    w = 28'(n * 28'h9E3779 + c * 28'h2B5A3 + 28'h1234567);
    w[24] = (n >= ls);
    return w;
  endfunction
  // Y lags x by one word and z by two, so the aligner must equalise them.
  wire [27:0] wx = gen(0, m, lstart);
  wire [27:0] wy = gen(1, m - 1, lstart);
  wire [27:0] wz = gen(2, m - 2, lstart);
  vlrx_tx_model tx_x (.i_clk(i_clk), .i_word(wx), .o_lane(xl), .o_clk_lane(xc), .o_take(tk));
  vlrx_tx_model tx_y (.i_clk(i_clk), .i_word(wy), .o_lane(yl), .o_clk_lane(yc), .o_take());
  vlrx_tx_model tx_z (.i_clk(i_clk), .i_word(wz), .o_lane(zl), .o_clk_lane(zc), .o_take());
  // Late inputs only matter in half-rate mode; they get a changing pattern, never a constant.
  vlrx_rx_top #(.P_PROBE_CYCLES(P)) dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_rst(i_rst),
    // Camera control lines and the serial port belong to outside logic, so the receiver has no pins for them.
    .i_link_size(size), .i_half_rate(1'b0), .i_wide_mode(wide),
    .i_x_lane(xl), .i_x_lane_late(~xl), .i_x_channel_clock(xc), .i_x_channel_clock_late(~xc),
    .i_y_lane(yl), .i_y_lane_late(~yl), .i_y_channel_clock(yc), .i_y_channel_clock_late(~yc),
    .i_z_lane(zl), .i_z_lane_late(~zl), .i_z_channel_clock(zc), .i_z_channel_clock_late(~zc),
    .i_pixel_ready(ready), .o_pixel_valid(vld), .o_strobe(stb), .o_port_a(pa), .o_port_b(pb),
    .o_port_c(pc), .o_port_d(pd), .o_port_e(pe), .o_port_f(pf), .o_port_g(pg), .o_port_h(ph),
    .o_port_i(pi), .o_port_j(pj), .o_frame_valid_flag(fv), .o_line_valid_flag(lv),
    .o_data_valid_flag(dv), .o_aligned(algn), .o_overrun(ovr), .i_power_supervisor_reset(srst),
    .i_link_pll_lock_in(lock), .i_supply_sense_one(s1), .i_supply_sense_two(s2),
    .o_current_source_enable(en_i), .o_supply_feed_enable(en_v), .o_ground_return_enable(en_g));
  // Record sent words, collect taken words and count overruns.
  always @(posedge i_clk) begin
    if (tk) begin
      hx[m] <= wx;
      hy[m - 1] <= wy;
      hz[m - 2] <= wz;
      m <= m + 1;
    end
    if (stb) begin
      rq.push_back({pa, pb, pc, pd, pe, pf, pg, ph, pi, pj, fv, lv, dv});
    end
    if (ovr) begin
      n_ovr <= n_ovr + 1;
    end
  end
  // ==========
  // Expected port contents
  function automatic logic [7:0] pmap(input logic [27:0] w, input int k);
    if (k == 0) return {w[5], w[27], w[6], w[4:0]};
    if (k == 1) return {w[11], w[10], w[14:12], w[9:7]};
    return {w[17:16], w[22:18], w[15]};
  endfunction
  function automatic logic [82:0] expv(input int n);
    logic [27:0] x, y, z;
    x = hx[n];
    y = hy[n];
    z = hz[n];
    return {pmap(x, 0), pmap(x, 1), pmap(x, 2), pmap(y, 0), pmap(y, 1), pmap(y, 2), pmap(z, 0),
      pmap(z, 1), z[22:15], z[26:23], y[26:23], x[25], x[24], x[26]};
  endfunction
  task automatic chk(input string what, input logic [82:0] e, input logic [82:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic finish_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // Scenarios
  // Reset the link, start a line, then compare the taken words with the sent ones on np ports.
  task automatic t_link(input logic [1:0] sz, input logic wd, input int np);
    int k;
    logic [82:0] mk;
    mk = {~({80{1'b1}} >> (8 * np)), 3'h7};
    size = sz;
    wide = wd;
    ready = 1'b1;
    // A word still in flight when the link reset ends must not carry a stale line start.
    lstart <= 1 << 20;
    i_rst = 1'b1;
    cyc(8);
    chk("aligned in link reset", 0, algn);
    i_rst = 1'b0;
    lstart <= m + 6;
    cyc(4);
    rq.delete();
    cyc(7 * 40);
    chk("aligned", 1, algn);
    chk("words taken", 1, rq.size() >= 20);
    k = -1;
    for (int n = 2; n < m - 3; n++) if ((expv(n) & mk) === (rq[0] & mk)) k = n;
    for (int i = 0; i < 20; i++) chk("port word", expv(k + i) & mk, rq[i] & mk);
  endtask
  // Stall the consumer until the buffer refuses, then drain it.
  task automatic t_stall;
    int i;
    int n0;
    ready = 1'b0;
    n0 = n_ovr;
    cyc(7 * 12);
    chk("valid while stalled", 1, vld);
    chk("words dropped", 1, n_ovr - n0 >= 8);
    ready = 1'b1;
    for (i = 0; i < 14 && vld; i++) cyc(1);
    chk("buffer drained", 0, vld);
  endtask
  // Walk the power supervisor through passive, probe, power, unpowered camera and its own reset.
  task automatic t_power;
    int i;
    lock = 1'b1;
    cyc(3 * P);
    chk("enables with link clock", 0, {en_i, en_v, en_g});
    lock = 1'b0;
    for (i = 0; i < 3 * P && !en_i; i++) cyc(1);
    chk("current source on", 1, en_i);
    s1 = 1'b1;
    for (i = 0; i < 3 * P && !en_v; i++) cyc(1);
    chk("feed and ground on", 2'h3, {en_v, en_g});
    s2 = 1'b1;
    cyc(8);
    chk("feed off on second sense", 0, {en_v, en_g});
    s1 = 1'b0;
    s2 = 1'b0;
    for (i = 0; i < 3 * P && !en_i; i++) cyc(1);
    for (i = 0; i < 3 * P && en_i; i++) cyc(1);
    cyc(4);
    chk("unpowered camera", 0, {en_i, en_v, en_g});
    for (i = 0; i < 3 * P && !en_i; i++) cyc(1);
    srst = 1'b1;
    cyc(4);
    chk("supervisor reset", 0, {en_i, en_v, en_g});
    srst = 1'b0;
  endtask
  initial begin
    cyc(4);
    i_rst_b = 1'b1;
    cyc(1);
    chk("quiet after reset", 0, {vld, algn, ovr, en_i, en_v, en_g});
    cyc(3);
    t_link(2'h0, 1'b0, 3);
    t_link(2'h1, 1'b0, 6);
    t_link(2'h2, 1'b1, 10);
    t_stall;
    t_power;
    finish_test;
  end
  // Watchdog well beyond the expected run of about twelve hundred cycles.
  initial begin
    cyc(10000);
    num_errors++;
    $display("ERROR watchdog expected end seen hang");
    finish_test;
  end
endmodule
